// ==== hdl/pdm_defines.svh ====
// power-down controller constants: register offset, field positions, reset values
// assumes inclusion by bare name from the design module and the testbench
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH
`define STBY_CTRL_OFFSET 32'hffff8614
`define STBY_CTRL_RESET 8'h1f
`define STBY_SEL_BIT 7
`define PORT_FLOAT_BIT 6
`define STBY_RSVD_ONES 8'h1f
`define STBY_RSVD_MASK 8'h3f
`define RD_UNMAPPED 8'h00
`endif

// ==== hdl/pdm_pkg.sv ====
// types shared by the power-down mode controller
// uses no macros from pdm_defines.svh
package pdm_pkg;
	// power state of the device
	typedef enum logic [1:0] {
		ST_RUN,
		ST_SLEEP,
		ST_STANDBY
	} pwr_state_e;
	// register bus request
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	// wake sources seen by the controller
	typedef struct packed {
		logic irq_accepted;
		logic addr_err;
	} wake_src_s;
endpackage

// ==== hdl/power_down_mode_control.sv ====
// power-down mode controller: sleep and standby entry and exit, standby control register
// assumes cpu raises a one-cycle halt pulse, interrupt logic reports only accepted interrupts,
// and the manual reset pin arrives synchronous to CLK_SYS
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "pdm_defines.svh"

module power_down_mode_control (
	input wire logic CLK_SYS, // 25 MHz system clock
	input wire logic RSTN, // async active-low power-on reset
	input wire logic MANUAL_RESET_N, // manual reset pin, active low
	input wire pdm_pkg::reg_req_s REG_REQ, // register bus request
	output logic [7:0] REG_RDATA, // read data, one cycle after read strobe
	input wire logic HALT_EXEC, // one-cycle pulse: cpu executes halt instruction
	input wire pdm_pkg::wake_src_s WAKE, // accepted interrupt, address error
	input wire logic WDT_RUN_ENABLE, // watchdog running
	output logic CPU_HALT, // cpu stopped
	output logic CLK_GATE, // clock stopped (standby)
	output logic PERIPH_HALT, // peripherals stopped (standby)
	output logic PORT_FLOAT, // port pins to high impedance
	output logic PORT_HOLD, // port pins frozen at current state
	output logic WAKE_EXC, // pulse: start exception processing on wake
	output logic MANUAL_RESET_OUT, // pulse: manual reset issued
	output pdm_pkg::pwr_state_e PWR_STATE // current power state
);
	import pdm_pkg::*;

	logic rst_s1_r, rst_s2_r;
	logic stby_sel_r, port_float_sel_r;
	pwr_state_e state_r, state_nxt;
	logic manual_reset_n_prev_r;
	logic manual_reset_n_event;

	// reset release synchroniser; assertion is asynchronous
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	function automatic logic hit(input reg_req_s q);
		hit = (q.addr == `STBY_CTRL_OFFSET);
	endfunction

	// standby decode, shared by the gating and port mode outputs
	function automatic logic is_standby(input pwr_state_e s);
		is_standby = (s == ST_STANDBY);
	endfunction

	// any wake source other than a reset; interrupts arrive already filtered by priority and mask
	function automatic logic wake_any(input wake_src_s w);
		wake_any = w.irq_accepted || w.addr_err;
	endfunction

	// control bits; setting refused while watchdog runs, clearing always allowed
	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			stby_sel_r <= 1'b0; // top bit of the reset value
			port_float_sel_r <= 1'b0;
		end else if (REG_REQ.wr && hit(REG_REQ)) begin
			if (!(REG_REQ.wdata[`STBY_SEL_BIT] && WDT_RUN_ENABLE))
				stby_sel_r <= REG_REQ.wdata[`STBY_SEL_BIT];
			if (!(REG_REQ.wdata[`PORT_FLOAT_BIT] && WDT_RUN_ENABLE))
				port_float_sel_r <= REG_REQ.wdata[`PORT_FLOAT_BIT];
		end
	end

	// read data, registered; reserved bits are constant and writes to them ignored
	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			REG_RDATA <= 8'h00;
		end else if (REG_REQ.rd && hit(REG_REQ)) begin
			REG_RDATA <= {stby_sel_r, port_float_sel_r, 6'h00} | `STBY_RSVD_ONES;
		end else begin
			REG_RDATA <= `RD_UNMAPPED;
		end
	end

	// manual reset acts on falling pin edge; power-on is high here since we run
	assign manual_reset_n_event = manual_reset_n_prev_r && !MANUAL_RESET_N;

	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			manual_reset_n_prev_r <= 1'b1;
		end else begin
			manual_reset_n_prev_r <= MANUAL_RESET_N;
		end
	end

	// power state; standby has no exit but the async power-on reset
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (HALT_EXEC)
					state_nxt = stby_sel_r ? ST_STANDBY : ST_SLEEP;
			end
			ST_SLEEP: begin
				if (manual_reset_n_event || WAKE.irq_accepted || WAKE.addr_err)
					state_nxt = ST_RUN;
			end
			ST_STANDBY: begin
				state_nxt = ST_STANDBY;
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
		if (manual_reset_n_event && state_r != ST_STANDBY)
			state_nxt = ST_RUN;
	end

	// power-on reset returns to run from any state
	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// power state mirror; the cpu stops on the edge after the halt pulse
	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			PWR_STATE <= ST_RUN;
		end else begin
			PWR_STATE <= state_nxt;
		end
	end

	// halt and gating levels follow next state: a wider cone traded for no extra latency
	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			CPU_HALT <= 1'b0;
			CLK_GATE <= 1'b0;
			PERIPH_HALT <= 1'b0;
		end else begin
			CPU_HALT <= (state_nxt != ST_RUN);
			CLK_GATE <= is_standby(state_nxt);
			PERIPH_HALT <= is_standby(state_nxt);
		end
	end

	// port pin mode only matters in standby; outside it the pins behave normally
	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			PORT_FLOAT <= 1'b0;
			PORT_HOLD <= 1'b0;
		end else begin
			PORT_FLOAT <= is_standby(state_nxt) && port_float_sel_r;
			PORT_HOLD <= is_standby(state_nxt) && !port_float_sel_r;
		end
	end

	// one-cycle pulses; manual reset takes precedence over exception start
	always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			WAKE_EXC <= 1'b0;
			MANUAL_RESET_OUT <= 1'b0;
		end else begin
			WAKE_EXC <= (state_r == ST_SLEEP) && !manual_reset_n_event && wake_any(WAKE);
			MANUAL_RESET_OUT <= manual_reset_n_event && (state_r != ST_STANDBY);
		end
	end

	// assertions: entry into the low-power states
	// sleep entry; a manual reset in the same cycle keeps the device running
	AST_SLEEP_ENTRY: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_RUN && HALT_EXEC && !stby_sel_r && !manual_reset_n_event)
		|=> (state_r == ST_SLEEP && CPU_HALT && !CLK_GATE))
		else $error("halt with select clear did not enter sleep");
	// standby entry stops clock, cpu and peripherals together
	AST_STBY_ENTRY: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_RUN && HALT_EXEC && stby_sel_r && !manual_reset_n_event)
		|=> (CLK_GATE && PERIPH_HALT && CPU_HALT))
		else $error("halt with select set did not enter standby");
	// the cpu never stops without a halt pulse on the edge before
	AST_HALT_NEXT: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		$rose(CPU_HALT)
		|-> $past(HALT_EXEC))
		else $error("cpu halted without halt instruction");
	// in sleep the clock and the peripherals keep running
	AST_SLEEP_CLK_RUNS: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_SLEEP)
		|-> (CPU_HALT && !CLK_GATE && !PERIPH_HALT))
		else $error("sleep stopped the clock or peripherals");
	// in standby everything is stopped
	AST_STBY_ALL_HALT: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_STANDBY)
		|-> (CPU_HALT && CLK_GATE && PERIPH_HALT))
		else $error("standby left something running");
	// while running nothing is stopped
	AST_RUN_NO_HALT: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_RUN)
		|-> (!CPU_HALT && !CLK_GATE && !PERIPH_HALT))
		else $error("halt output set while running");
	// the reported state follows the internal state exactly
	AST_STATE_MIRROR: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		1'b1
		|-> (PWR_STATE == state_r))
		else $error("reported power state differs from internal state");
	// without a halt pulse the device stays running
	AST_RUN_STAYS: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_RUN && !HALT_EXEC)
		|=> (state_r == ST_RUN))
		else $error("left run without halt instruction");
	sequence s_halt_standby;
		state_r == ST_RUN && HALT_EXEC && stby_sel_r && !manual_reset_n_event;
	endsequence
	sequence s_standby_held;
		state_r == ST_STANDBY ##1 state_r == ST_STANDBY;
	endsequence
	// standby, once entered, is held over the following cycles
	AST_STBY_HELD: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		s_halt_standby
		|=> s_standby_held)
		else $error("standby not held after entry");

	// assertions: register access
	// read data carries both selects and the fixed reserved pattern
	AST_READ_VALUE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(REG_REQ.rd && hit(REG_REQ)) |=> (REG_RDATA[5:0] == 6'h1f)
			&& REG_RDATA[7] == $past(stby_sel_r) && REG_RDATA[6] == $past(port_float_sel_r))
		else $error("register read value wrong");
	// a running watchdog keeps standby select from rising
	AST_SEL_LOCK: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(WDT_RUN_ENABLE && !stby_sel_r)
		|=> !stby_sel_r)
		else $error("standby select set while watchdog runs");
	// a running watchdog keeps port float from rising
	AST_FLOAT_LOCK: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(WDT_RUN_ENABLE && !port_float_sel_r)
		|=> !port_float_sel_r)
		else $error("port float set while watchdog runs");
	// with the watchdog stopped a write lands in standby select
	AST_SEL_WRITE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(REG_REQ.wr && hit(REG_REQ) && !WDT_RUN_ENABLE)
		|=> (stby_sel_r == $past(REG_REQ.wdata[`STBY_SEL_BIT])))
		else $error("standby select write lost");
	// with the watchdog stopped a write lands in port float
	AST_FLOAT_WRITE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(REG_REQ.wr && hit(REG_REQ) && !WDT_RUN_ENABLE)
		|=> (port_float_sel_r == $past(REG_REQ.wdata[`PORT_FLOAT_BIT])))
		else $error("port float write lost");
	// clearing standby select is never refused
	AST_SEL_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(REG_REQ.wr && hit(REG_REQ) && !REG_REQ.wdata[`STBY_SEL_BIT])
		|=> !stby_sel_r)
		else $error("standby select clear refused");
	// without a write to the register both selects hold
	AST_NO_WRITE_HOLD: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		!(REG_REQ.wr && hit(REG_REQ))
		|=> ($stable(stby_sel_r) && $stable(port_float_sel_r)))
		else $error("select bit changed without a write");
	// read data stands only in the cycle after a read of the register
	AST_RDATA_IDLE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		!(REG_REQ.rd && hit(REG_REQ))
		|=> (REG_RDATA == `RD_UNMAPPED))
		else $error("read data not idle");

	// assertions: port pins
	// standby port mode follows port float select
	AST_PORT_MODE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_STANDBY)
		|-> (PORT_FLOAT == port_float_sel_r) && (PORT_HOLD != port_float_sel_r))
		else $error("standby port mode wrong");
	// pins are never both held and floated
	AST_FLOAT_EXCL: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		1'b1
		|-> !(PORT_FLOAT && PORT_HOLD))
		else $error("port pins both held and floated");
	// outside standby the port mode outputs stay idle
	AST_PORT_RUN: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r != ST_STANDBY)
		|-> (!PORT_FLOAT && !PORT_HOLD))
		else $error("port mode active outside standby");

	// assertions: leaving sleep
	// an accepted wake source in sleep with no manual reset beside it
	sequence s_sleep_wake;
		state_r == ST_SLEEP && wake_any(WAKE) && !manual_reset_n_event;
	endsequence
	AST_SLEEP_WAKE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		s_sleep_wake
		|=> (WAKE_EXC && !CPU_HALT && state_r == ST_RUN))
		else $error("wake source did not end sleep");
	// with no wake source sleep is held
	AST_SLEEP_HOLD: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_SLEEP && !wake_any(WAKE) && !manual_reset_n_event)
		|=> (state_r == ST_SLEEP))
		else $error("sleep left without wake source");
	// exception start is a single-cycle pulse
	AST_WAKE_ONE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		WAKE_EXC
		|=> !WAKE_EXC)
		else $error("exception start longer than one cycle");
	// exception start only follows a cycle in sleep
	AST_WAKE_ONLY_SLEEP: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		WAKE_EXC
		|-> ($past(state_r) == ST_SLEEP))
		else $error("exception start outside sleep");
	// manual reset ends sleep
	AST_MANUAL_RESET_N: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_SLEEP && manual_reset_n_event)
		|=> (MANUAL_RESET_OUT && state_r == ST_RUN))
		else $error("manual reset did not end sleep");
	// manual reset output is a single-cycle pulse
	AST_MANUAL_RESET_N_PULSE: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		MANUAL_RESET_OUT
		|=> !MANUAL_RESET_OUT)
		else $error("manual reset pulse longer than one cycle");
	// a manual reset never starts wake exception processing
	AST_MANUAL_RESET_N_NO_EXC: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		manual_reset_n_event
		|=> !WAKE_EXC)
		else $error("exception start beside manual reset");

	// assertions: standby exit and power-on reset
	// standby is left only through power-on reset
	AST_STBY_STAYS: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_STANDBY)
		|=> (state_r == ST_STANDBY && !WAKE_EXC))
		else $error("standby left without power-on reset");
	// manual reset is ignored in standby
	AST_MANUAL_RESET_N_NO_STBY: assert property (@(posedge CLK_SYS) disable iff (!rst_s2_r)
		(state_r == ST_STANDBY)
		|=> !MANUAL_RESET_OUT)
		else $error("manual reset issued in standby");
	// power-on reset brings the device back to run
	AST_POR_RUN: assert property (@(posedge CLK_SYS)
		$rose(rst_s2_r)
		|-> (state_r == ST_RUN && !CPU_HALT))
		else $error("not in run after power-on reset");
endmodule // power_down_mode_control

// ==== bench/pdm_cpu_model.sv ====
// cpu-side model: halt pulses, accepted wake events, watchdog enable, manual reset pin
// assumes the bench calls its tasks from one process clocked by clk
`timescale 1ns/1ps
module pdm_cpu_model (
	input wire logic clk, // system clock
	output logic halt_exec, // halt instruction pulse
	output pdm_pkg::wake_src_s wake, // accepted interrupt, address error
	output logic wdt_run, // watchdog running
	output logic manual_reset_n_n // manual reset pin
);
	import pdm_pkg::*;
	// idle levels; the watchdog runs out of reset, so selects start out blocked
	initial begin
		halt_exec = 1'b0;
		wake = '0;
		wdt_run = 1'b1;
		manual_reset_n_n = 1'b1;
	end
	// one-cycle halt instruction
	task halt();
		@(posedge clk) halt_exec <= 1'b1;
		@(posedge clk) halt_exec <= 1'b0;
	endtask
	// event k: 0 interrupt (already priority filtered), 1 address error, 2 manual reset
	task event_in(input int k);
		@(posedge clk) begin
			wake.irq_accepted <= (k == 0);
			wake.addr_err <= (k == 1);
			manual_reset_n_n <= (k != 2);
		end
		@(posedge clk) begin
			wake <= '0;
			manual_reset_n_n <= 1'b1;
		end
	endtask
	// drives the watchdog run level; the bench stops it before the select writes meant to land
	task wdt(input logic v);
		@(posedge clk) wdt_run <= v;
	endtask
endmodule // pdm_cpu_model

// ==== bench/testbench.sv ====
// self-checking bench for the power-down mode controller: register access, sleep and standby
// assumes pdm_cpu_model drives the cpu-side inputs and pdm_defines.svh is on the include path
`timescale 1ns/1ps
`include "pdm_defines.svh"
module testbench;
	import pdm_pkg::*;
	logic clk, rstn, halt, cpu_halt, clk_gate, periph_halt, port_float, port_hold, wake_exc, manual_reset_n_out, wdt, manual_reset_n_n;
	reg_req_s req;
	logic [7:0] rdata;
	wake_src_s wake;
	pwr_state_e st;
	wire [7:0] outs = {1'b0, cpu_halt, clk_gate, periph_halt, port_float, port_hold, st};
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	pdm_cpu_model cpu (.clk(clk), .halt_exec(halt), .wake(wake), .wdt_run(wdt), .manual_reset_n_n(manual_reset_n_n));
	power_down_mode_control dut (.CLK_SYS(clk), .RSTN(rstn), .MANUAL_RESET_N(manual_reset_n_n), .REG_REQ(req),
		.REG_RDATA(rdata), .HALT_EXEC(halt), .WAKE(wake), .WDT_RUN_ENABLE(wdt), .CPU_HALT(cpu_halt),
		.CLK_GATE(clk_gate), .PERIPH_HALT(periph_halt), .PORT_FLOAT(port_float), .PORT_HOLD(port_hold),
		.WAKE_EXC(wake_exc), .MANUAL_RESET_OUT(manual_reset_n_out), .PWR_STATE(st));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// the run needs about 80 cycles; a hang past 2000 cycles counts as a mismatch
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_fail++;
			print_verdict();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// register bus: one-cycle strobes, read data sampled in the cycle after the strobe
	task wr(input logic [31:0] a, input logic [7:0] v);
		@(posedge clk) req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk) req.wr <= 1'b0;
	endtask
	task rd(input logic [31:0] a, output logic [7:0] v);
		@(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) req.rd <= 1'b0;
		#1 v = rdata;
	endtask
	// power-on reset through the two-stage release
	task por();
		@(posedge clk) rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		logic [7:0] d, e;
		rstn = 1'b0;
		req = '0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`STBY_CTRL_OFFSET, d);
		chk(d, 8'h1f);
		wr(`STBY_CTRL_OFFSET, 8'hdf);
		rd(`STBY_CTRL_OFFSET, d);
		chk(d, 8'h1f);
		rd(32'hffff8618, d);
		chk(d, 8'h00);
		cpu.wdt(1'b0);
		wr(`STBY_CTRL_OFFSET, 8'h5f);
		rd(`STBY_CTRL_OFFSET, d);
		chk(d, 8'h5f);
		wr(`STBY_CTRL_OFFSET, 8'h1f);
		$display("test register done");
		// sleep, then each wake source other than power-on reset
		for (int k = 0; k < 3; k++) begin
			cpu.halt();
			#1 chk(outs & 8'hfb, {6'b010000, ST_SLEEP});
			cpu.event_in(k);
			#1 chk({6'b0, wake_exc, manual_reset_n_out}, (k == 2) ? 8'h01 : 8'h02);
			chk(outs, {6'b0, ST_RUN});
		end
		$display("test sleep done");
		// standby holds through every event except power-on reset
		for (int f = 0; f < 2; f++) begin
			e = {2'b00, 2'b11, f[0], !f[0], ST_STANDBY};
			wr(`STBY_CTRL_OFFSET, f[0] ? 8'hdf : 8'h9f);
			cpu.halt();
			#1 chk({wake_exc, manual_reset_n_out, outs[5:0]}, e);
			for (int k = 0; k < 3; k++) begin
				cpu.event_in(k);
				#1 chk({wake_exc, manual_reset_n_out, outs[5:0]}, e);
			end
			por();
			chk(outs, {6'b0, ST_RUN});
			rd(`STBY_CTRL_OFFSET, d);
			chk(d, 8'h1f);
		end
		cpu.halt();
		por();
		chk(outs, {6'b0, ST_RUN});
		$display("test standby done");
		print_verdict();
	end
endmodule // testbench
